// ### rtl/mode_set_pkg.sv
// Constants, encodings and decode helper for the microcore mode-set logic.
// Assumes 16-bit instruction words and a single 40 MHz core clock.
`default_nettype none
package mode_set_pkg;
    // Opcode patterns and masks (mask bit 1 = fixed bit)
    localparam logic [15:0] OP_CRB  = 16'h3740;
    localparam logic [15:0] MSK_CRB = 16'hFFE8;
    localparam logic [15:0] OP_CRT  = 16'h358C;
    localparam logic [15:0] OP_DCC  = 16'h3542;
    localparam logic [15:0] OP_DM   = 16'h3584;
    localparam logic [15:0] OP_DRM  = 16'h3580;
    localparam logic [15:0] MSK_2B  = 16'hFFFC;
    localparam logic [15:0] MSK_1B  = 16'hFFFE;
    // Operand field positions
    localparam int unsigned CRB_LVL_POS = 4;
    localparam int unsigned HI_POS      = 8;
    localparam int unsigned OFS_W       = 6;
    localparam int unsigned N4_W        = 4;
    // DAC write strobe positions
    localparam int unsigned WR_VALUE = 0;
    localparam int unsigned WR_OFS   = 1;
    localparam int unsigned WR_4H    = 2;
    localparam int unsigned WR_4NEG  = 3;
    localparam int unsigned WR_BOOST = 4;
    // Reset values
    localparam logic [7:0] RST_CTRL_HI = 8'h00;
    localparam logic       RST_CONV    = 1'b0;
    // Mode encodings, in operand order
    typedef enum logic [1:0] {SEL_SSSC, SEL_OSSC, SEL_SSOC, SEL_OSOC} share_sel_t;
    typedef enum logic [1:0] {DAC_BOOST, DAC_VALUE, DAC_OFFSET, DAC_FULL} dac_mode_t;
    typedef enum logic [1:0] {RAM_WORD, RAM_LOW, RAM_HIGH, RAM_SWAP} ram_mode_t;

    // Masked opcode compare
    function automatic logic op_match(input logic [15:0] w, input logic [15:0] op,
                                      input logic [15:0] msk);
        return (w & msk) == op;
    endfunction : op_match
endpackage : mode_set_pkg
`default_nettype wire

// ### rtl/mode_if.sv
// Mode settings passed from the decoder to its helper blocks.
// Assumes one driver (src) and any number of readers (snk).
`default_nettype none
interface mode_if;
    import mode_set_pkg::*;
    logic      converter_mode; // 1 = autonomous regulation
    ram_mode_t ram_mode;       // Data RAM read shaping
    modport src (output converter_mode, output ram_mode);
    modport snk (input converter_mode, input ram_mode);
endinterface : mode_if
`default_nettype wire

// ### rtl/converter_regulator.sv
// Low-side converter pre-driver control: core drive or hysteresis loop.
// Assumes comparator pins are asynchronous to clk.
`default_nettype none
module converter_regulator import mode_set_pkg::*; (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Mode
    mode_if.snk       cfg,
    // Drive sources
    input  wire logic core_drive,
    input  wire logic below_4l_pin,
    input  wire logic above_4h_pin,
    // Pre-driver
    output logic      lowside
);
    typedef struct packed {
        logic [2:0] lo_sync; // Synchroniser chain, below 4l
        logic [2:0] hi_sync; // Synchroniser chain, above 4h
        logic       lo_f;    // Agreed level
        logic       hi_f;
        logic       drive;
    } reg_st_t;
    reg_st_t st_ff;
    reg_st_t nxt_st;

    ////////////////////////////////////////////////////////////////
    // Next state: a level counts once stages two and three agree
    always_comb begin
        nxt_st = st_ff;
        nxt_st.lo_sync = {st_ff.lo_sync[1:0], below_4l_pin};
        nxt_st.hi_sync = {st_ff.hi_sync[1:0], above_4h_pin};
        if (st_ff.lo_sync[1] == st_ff.lo_sync[2]) begin
            nxt_st.lo_f = st_ff.lo_sync[2];
        end
        if (st_ff.hi_sync[1] == st_ff.hi_sync[2]) begin
            nxt_st.hi_f = st_ff.hi_sync[2];
        end
        if (!cfg.converter_mode) begin
            nxt_st.drive = core_drive;
        end else if (st_ff.hi_f) begin
            // Over limit wins, so a bad comparator pair cannot latch on
            nxt_st.drive = 1'b0; // [RULE9]
        end else if (st_ff.lo_f) begin
            nxt_st.drive = 1'b1; // [RULE9]
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign lowside = st_ff.drive;

    property p_reg_off;
        @(posedge clk) disable iff (!nrst)
        cfg.converter_mode && st_ff.hi_f |=> !lowside;
    endproperty
    a_reg_off: assert property (p_reg_off) else $error("regulator left on above 4h"); // [RULE9]
endmodule : converter_regulator
`default_nettype wire

// ### rtl/ram_read_shaper.sv
// Shapes Data RAM read words for load instructions by read mode.
// Assumes one read word per ram_rd_valid pulse.
`default_nettype none
module ram_read_shaper import mode_set_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Mode
    mode_if.snk              cfg,
    // Raw read
    input  wire logic        rd_valid,
    input  wire logic [15:0] rd_word,
    // Shaped read
    output logic [15:0]      rd_result,
    output logic             rd_done
);
    typedef struct packed {
        logic        done;
        logic [15:0] data;
    } shp_st_t;
    shp_st_t st_ff;
    shp_st_t nxt_st;

    ////////////////////////////////////////////////////////////////
    // Mode is sampled with the read, so earlier loads are untouched
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = rd_valid;
        if (rd_valid) begin // [RULE20]
            unique case (cfg.ram_mode)
                RAM_WORD: nxt_st.data = rd_word;
                RAM_LOW:  nxt_st.data = {8'h00, rd_word[7:0]};   // [RULE17]
                RAM_HIGH: nxt_st.data = {8'h00, rd_word[15:8]};  // [RULE18]
                RAM_SWAP: nxt_st.data = {rd_word[7:0], rd_word[15:8]}; // [RULE19]
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign rd_result = st_ff.data;
    assign rd_done   = st_ff.done;

    property p_byte_clr;
        @(posedge clk) disable iff (!nrst)
        rd_valid && (cfg.ram_mode inside {RAM_LOW, RAM_HIGH}) |=> rd_result[15:8] == 8'h00;
    endproperty
    a_byte_clr: assert property (p_byte_clr) else $error("byte mode upper byte not clear"); // [RULE18]

    property p_swap;
        @(posedge clk) disable iff (!nrst)
        rd_valid && cfg.ram_mode == RAM_SWAP |=> rd_result == {$past(rd_word[7:0]), $past(rd_word[15:8])};
    endproperty
    a_swap: assert property (p_swap) else $error("swap read wrong"); // [RULE19]
endmodule : ram_read_shaper
`default_nettype wire

// ### rtl/microcore_mode_set.sv
// Mode-set instruction decoder and executor for one microcore.
// Assumes one instruction per instr_valid pulse and peer cores on clk.
`default_nettype none
// Function
// RULE1 - Set-bit writes level into one control bit
// RULE2 - Select codes 000..111 map to bits 8..15
// RULE3 - Level in bit 4, zero bit 3, select 2:0
// RULE4 - Own shared register; peers' registers are readable
// RULE5 - Shared select code sits in instruction bits 1:0
// RULE6 - Codes: self, other core, same other channel, both
// RULE7 - Shared select resets to own register
// RULE8 - Converter mode bit 0: core or autonomous
// RULE9 - Autonomous mode regulates pre-driver between 4l, 4h
// RULE10 - Converter mode resets to core control
// RULE11 - DAC mode: boost, value/4h, offset/4neg, both
// RULE12 - Combined address picks register; mode 00 plain none
// RULE13 - Value and 4h use the low eight bits
// RULE14 - Offset in bits 13:8, 4neg in 11:8
// RULE15 - DAC mode resets to value/4h
// RULE16 - Read mode: word, low, high, swapped
// RULE17 - Low byte lands in destination low byte
// RULE18 - High byte moves low; upper byte cleared
// RULE19 - Swap mode exchanges the two bytes
// RULE20 - Read mode affects only later loads
// RULE21 - Read mode resets to full word
// RULE22 - Settings held per core until rewritten
module microcore_mode_set import mode_set_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Instruction stream
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    // Control register upper byte
    output logic [7:0]       ctrl_hi_bits,
    // Shared communication registers
    input  wire logic        comm_wr,
    input  wire logic [15:0] comm_wdata,
    output logic [15:0]      channel_shared_comm_reg,
    input  wire logic        comm_rd,
    input  wire logic [15:0] peer_comm_ossc,
    input  wire logic [15:0] peer_comm_ssoc,
    input  wire logic [15:0] peer_comm_osoc,
    output logic [15:0]      comm_rdata,
    output logic             comm_rd_done,
    // Converter control
    input  wire logic        core_lowside_drive,
    input  wire logic        below_4l_pin,
    input  wire logic        above_4h_pin,
    output logic             converter_lowside_predriver,
    output logic             converter_mode_sel,
    // DAC data access
    input  wire logic        dac_acc_valid,
    input  wire logic        dac_acc_write,
    input  wire logic        dac_acc_combined,
    input  wire logic [15:0] dac_wdata,
    input  wire logic [7:0]  dac_value_in,
    input  wire logic [5:0]  dac_offset_in,
    input  wire logic [7:0]  dac_4h_in,
    input  wire logic [3:0]  dac_4neg_in,
    input  wire logic [7:0]  dac_boost_in,
    output logic [15:0]      dac_rdata,
    output logic             dac_rd_done,
    output logic [4:0]       dac_wr_strobe,
    output logic [15:0]      dac_wr_data,
    output logic [1:0]       dac_slice_sel,
    // Data RAM reads
    input  wire logic        ram_rd_valid,
    input  wire logic [15:0] ram_rd_word,
    output logic [15:0]      ram_rd_result,
    output logic             ram_rd_done,
    output logic [1:0]       ram_read_mode_sel
);
    typedef struct packed {
        logic [7:0]  ctrl_hi;   // Control bits 15..8
        share_sel_t  share_sel; // Shared register target
        logic        conv_mode; // Converter regulation mode
        dac_mode_t   dac_mode;  // DAC slice mode
        ram_mode_t   ram_mode;  // Data RAM read mode
        logic [15:0] own_comm;  // This core's shared register
        logic [15:0] comm_rd;   // Shared read data
        logic        comm_done;
        logic [15:0] dac_rd;    // DAC read data
        logic        dac_done;
        logic [4:0]  dac_wr;    // DAC write strobes
        logic [15:0] dac_wdat;
    } core_st_t;

    localparam core_st_t ST_RST = '{
        ctrl_hi:   RST_CTRL_HI,
        share_sel: SEL_SSSC,
        conv_mode: RST_CONV,
        dac_mode:  DAC_VALUE,
        ram_mode:  RAM_WORD,
        default:   '0
    };

    core_st_t st_ff;  // Whole state of this core
    core_st_t nxt_st; // Next state
    mode_if   cfg (); // Modes to helpers

    // Decoded instruction strobes
    logic is_crb;
    logic is_crt;
    logic is_dcc;
    logic is_dm;
    logic is_drm;
    logic [2:0] ctrl_bit_select; // Selected control bit

    ////////////////////////////////////////////////////////////////
    // Instruction decode
    assign is_crb = instr_valid && op_match(instr_word, OP_CRB, MSK_CRB); // [RULE3]
    assign is_crt = instr_valid && op_match(instr_word, OP_CRT, MSK_2B);  // [RULE5]
    assign is_dcc = instr_valid && op_match(instr_word, OP_DCC, MSK_1B);  // [RULE8]
    assign is_dm  = instr_valid && op_match(instr_word, OP_DM, MSK_2B);   // [RULE11]
    assign is_drm = instr_valid && op_match(instr_word, OP_DRM, MSK_2B);  // [RULE16]
    assign ctrl_bit_select = instr_word[2:0];

    ////////////////////////////////////////////////////////////////
    // Next state: mode execution and access handling
    always_comb begin
        nxt_st = st_ff;
        nxt_st.comm_done = comm_rd;
        nxt_st.dac_done  = dac_acc_valid && !dac_acc_write;
        nxt_st.dac_wr    = '0;
        // Mode instructions; each leaves the other settings alone
        if (is_crb) begin
            // Code n reaches bit 8+n; others keep their level
            nxt_st.ctrl_hi[ctrl_bit_select] = instr_word[CRB_LVL_POS]; // [RULE1] [RULE2]
        end
        if (is_crt) begin
            nxt_st.share_sel = share_sel_t'(instr_word[1:0]); // [RULE5]
        end
        if (is_dcc) begin
            nxt_st.conv_mode = instr_word[0]; // [RULE8]
        end
        if (is_dm) begin
            nxt_st.dac_mode = dac_mode_t'(instr_word[1:0]); // [RULE11]
        end
        if (is_drm) begin
            nxt_st.ram_mode = ram_mode_t'(instr_word[1:0]); // [RULE20]
        end
        // Own shared register, written by this core
        if (comm_wr) begin
            nxt_st.own_comm = comm_wdata; // [RULE4]
        end
        // Shared register read through the current target
        if (comm_rd) begin
            unique case (st_ff.share_sel) // [RULE6]
                SEL_SSSC: nxt_st.comm_rd = st_ff.own_comm;
                SEL_OSSC: nxt_st.comm_rd = peer_comm_ossc;
                SEL_SSOC: nxt_st.comm_rd = peer_comm_ssoc;
                SEL_OSOC: nxt_st.comm_rd = peer_comm_osoc;
            endcase
        end
        // DAC access; slices picked by the current DAC mode
        if (dac_acc_valid) begin
            nxt_st.dac_rd   = '0;
            nxt_st.dac_wdat = dac_wdata;
            if (dac_acc_combined) begin
                unique case (st_ff.dac_mode) // [RULE12]
                    DAC_BOOST: begin
                        nxt_st.dac_rd[7:0] = dac_boost_in;
                        nxt_st.dac_wr[WR_BOOST] = dac_acc_write;
                    end
                    DAC_VALUE: begin
                        nxt_st.dac_rd[7:0] = dac_4h_in; // [RULE13]
                        nxt_st.dac_wr[WR_4H] = dac_acc_write;
                    end
                    DAC_OFFSET: begin
                        nxt_st.dac_rd[HI_POS +: N4_W] = dac_4neg_in; // [RULE14]
                        nxt_st.dac_wr[WR_4NEG] = dac_acc_write;
                    end
                    DAC_FULL: begin
                        nxt_st.dac_rd[7:0] = dac_4h_in;
                        nxt_st.dac_rd[HI_POS +: N4_W] = dac_4neg_in;
                        nxt_st.dac_wr[WR_4H] = dac_acc_write;
                        nxt_st.dac_wr[WR_4NEG] = dac_acc_write;
                    end
                endcase
            end else begin
                unique case (st_ff.dac_mode) // [RULE11]
                    DAC_BOOST: begin
                        // Plain DAC address reaches nothing here
                        nxt_st.dac_rd = '0; // [RULE12]
                    end
                    DAC_VALUE: begin
                        nxt_st.dac_rd[7:0] = dac_value_in; // [RULE13]
                        nxt_st.dac_wr[WR_VALUE] = dac_acc_write;
                    end
                    DAC_OFFSET: begin
                        nxt_st.dac_rd[HI_POS +: OFS_W] = dac_offset_in; // [RULE14]
                        nxt_st.dac_wr[WR_OFS] = dac_acc_write;
                    end
                    DAC_FULL: begin
                        nxt_st.dac_rd[7:0] = dac_value_in;
                        nxt_st.dac_rd[HI_POS +: OFS_W] = dac_offset_in;
                        nxt_st.dac_wr[WR_VALUE] = dac_acc_write;
                        nxt_st.dac_wr[WR_OFS] = dac_acc_write;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // State register; private to this core
    always_ff @(posedge clk or negedge nrst) begin // [RULE22]
        if (!nrst) begin
            st_ff <= ST_RST; // [RULE7] [RULE10] [RULE15] [RULE21]
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs and helper blocks
    assign cfg.converter_mode = st_ff.conv_mode;
    assign cfg.ram_mode       = st_ff.ram_mode;
    assign ctrl_hi_bits            = st_ff.ctrl_hi;
    assign channel_shared_comm_reg = st_ff.own_comm;
    assign comm_rdata              = st_ff.comm_rd;
    assign comm_rd_done            = st_ff.comm_done;
    assign converter_mode_sel      = st_ff.conv_mode;
    assign dac_rdata               = st_ff.dac_rd;
    assign dac_rd_done             = st_ff.dac_done;
    assign dac_wr_strobe           = st_ff.dac_wr;
    assign dac_wr_data             = st_ff.dac_wdat;
    assign dac_slice_sel           = st_ff.dac_mode;
    assign ram_read_mode_sel       = st_ff.ram_mode;

    // Pre-driver source selection and hysteresis
    converter_regulator u_reg (
        .clk          (clk),
        .nrst         (nrst),
        .cfg          (cfg),
        .core_drive   (core_lowside_drive),
        .below_4l_pin (below_4l_pin),
        .above_4h_pin (above_4h_pin),
        .lowside      (converter_lowside_predriver)
    );

    // Load-path byte shaping
    ram_read_shaper u_shp (
        .clk       (clk),
        .nrst      (nrst),
        .cfg       (cfg),
        .rd_valid  (ram_rd_valid),
        .rd_word   (ram_rd_word),
        .rd_result (ram_rd_result),
        .rd_done   (ram_rd_done)
    );

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_crb_bit;
        is_crb |=> ctrl_hi_bits[$past(instr_word[2:0])] == $past(instr_word[4]);
    endproperty
    a_crb_bit: assert property (p_crb_bit) else $error("control bit not written"); // [RULE1]

    property p_crb_keep;
        is_crb |=> ((ctrl_hi_bits ^ $past(ctrl_hi_bits)) & ~(8'h01 << $past(instr_word[2:0]))) == 8'h00;
    endproperty
    a_crb_keep: assert property (p_crb_keep) else $error("other control bits changed"); // [RULE2]

    property p_comm_done;
        comm_rd |=> comm_rd_done;
    endproperty
    a_comm_done: assert property (p_comm_done) else $error("shared read not answered"); // [RULE4]

    property p_comm_self;
        comm_rd && st_ff.share_sel == SEL_SSSC |=> comm_rdata == $past(st_ff.own_comm);
    endproperty
    a_comm_self: assert property (p_comm_self) else $error("own shared read wrong"); // [RULE6]

    property p_comm_osoc;
        comm_rd && st_ff.share_sel == SEL_OSOC |=> comm_rdata == $past(peer_comm_osoc);
    endproperty
    a_comm_osoc: assert property (p_comm_osoc) else $error("far shared read wrong"); // [RULE4]

    property p_sel_set;
        is_crt |=> st_ff.share_sel == $past(instr_word[1:0]);
    endproperty
    a_sel_set: assert property (p_sel_set) else $error("shared select not taken"); // [RULE5]

    property p_dcc;
        is_dcc |=> converter_mode_sel == $past(instr_word[0]) ##1 ($stable(converter_mode_sel) || $past(instr_valid));
    endproperty
    a_dcc: assert property (p_dcc) else $error("converter mode not taken"); // [RULE8]

    property p_hold;
        !instr_valid |=> $stable(ctrl_hi_bits) && $stable(dac_slice_sel) && $stable(ram_read_mode_sel);
    endproperty
    a_hold: assert property (p_hold) else $error("mode changed without instruction"); // [RULE22]

    property p_dac_null;
        dac_acc_valid && !dac_acc_combined && dac_slice_sel == 2'h0 |=> dac_wr_strobe == 5'h00 && dac_rdata == 16'h0000;
    endproperty
    a_dac_null: assert property (p_dac_null) else $error("plain DAC reached in boost mode"); // [RULE12]

    property p_dac_ofs;
        dac_acc_valid && !dac_acc_combined && dac_slice_sel == 2'h2 |=> dac_rdata == {2'h0, $past(dac_offset_in), 8'h00};
    endproperty
    a_dac_ofs: assert property (p_dac_ofs) else $error("offset read misplaced"); // [RULE14]

    property p_drm_late;
        is_drm ##1 ram_rd_valid |=> ram_read_mode_sel == $past(instr_word[1:0], 2) || $past(instr_valid);
    endproperty
    a_drm_late: assert property (p_drm_late) else $error("read mode not applied to later load"); // [RULE20]
endmodule : microcore_mode_set
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the microcore mode-set block.
// Assumes the design carries its own assertions; the bench drives every port.
`default_nettype none
module tb_top import mode_set_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    //////////////////////////////////////////////////////////////////////////
    // Clock, reset, counters
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    int          mismatches = 0;
    int          checked = 0;
    // Stimulus, all quiet at time zero
    logic        instr_valid = '0, comm_wr = '0, comm_rd = '0, core_lowside_drive = '0;
    logic        below_4l_pin = '0, above_4h_pin = '0, ram_rd_valid = '0;
    logic        dac_acc_valid = '0, dac_acc_write = '0, dac_acc_combined = '0;
    logic [15:0] instr_word = '0, comm_wdata = '0, dac_wdata = 16'h3FFF, ram_rd_word = 16'hA55C;
    logic [15:0] peer_comm_ossc = 16'h1A1A, peer_comm_ssoc = 16'h2B2B, peer_comm_osoc = 16'h3C3C;
    logic [7:0]  dac_value_in = 8'hC5, dac_4h_in = 8'hE7, dac_boost_in = 8'h96;
    logic [5:0]  dac_offset_in = 6'h2A;
    logic [3:0]  dac_4neg_in = 4'hB;
    // Observed outputs
    logic [7:0]  ctrl_hi_bits;
    logic [15:0] channel_shared_comm_reg, comm_rdata, dac_rdata, dac_wr_data, ram_rd_result;
    logic        comm_rd_done, converter_lowside_predriver, converter_mode_sel, dac_rd_done, ram_rd_done;
    logic [4:0]  dac_wr_strobe;
    logic [1:0]  dac_slice_sel, ram_read_mode_sel;

    microcore_mode_set u_dut (
        .clk, .nrst, .instr_valid, .instr_word, .ctrl_hi_bits, .comm_wr, .comm_wdata, .channel_shared_comm_reg,
        .comm_rd, .peer_comm_ossc, .peer_comm_ssoc, .peer_comm_osoc, .comm_rdata, .comm_rd_done,
        .core_lowside_drive, .below_4l_pin, .above_4h_pin, .converter_lowside_predriver, .converter_mode_sel,
        .dac_acc_valid, .dac_acc_write, .dac_acc_combined, .dac_wdata, .dac_value_in, .dac_offset_in, .dac_4h_in,
        .dac_4neg_in, .dac_boost_in, .dac_rdata, .dac_rd_done, .dac_wr_strobe, .dac_wr_data, .dac_slice_sel,
        .ram_rd_valid, .ram_rd_word, .ram_rd_result, .ram_rd_done, .ram_read_mode_sel
    );

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    //////////////////////////////////////////////////////////////////////////
    // Drive 2 ns past the edge so no race with the design's flops
    task automatic cyc(int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic exec(logic [15:0] w);
        // One idle edge first, so a back-to-back call never re-raises the strobe at once
        cyc();
        instr_valid = 1'b1;
        instr_word  = w;
        cyc();
        instr_valid = 1'b0;
    endtask : exec
    task automatic dac_acc(logic wr, logic comb);
        cyc();
        {dac_acc_valid, dac_acc_write, dac_acc_combined} = {1'b1, wr, comb};
        cyc();
        dac_acc_valid = 1'b0;
    endtask : dac_acc
    task automatic settle(logic e);
        // Pin path has a synchroniser; bounded wait
        repeat (12) if (converter_lowside_predriver !== e) cyc();
        chk("predriver", {15'h0000, e}, {15'h0000, converter_lowside_predriver});
    endtask : settle
    //////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("ctrl_hi_bits", 16'h0000, {8'h00, ctrl_hi_bits});
        chk("dac_slice_sel", 16'h0001, {14'h0000, dac_slice_sel});
        chk("ram_read_mode_sel", 16'h0000, {14'h0000, ram_read_mode_sel});
        chk("converter_mode_sel", 16'h0000, {15'h0000, converter_mode_sel});
        $display("reset test done");
    endtask : t_reset
    task automatic t_comm();
        logic [15:0] tbl [4] = '{16'h4D4D, 16'h1A1A, 16'h2B2B, 16'h3C3C};
        {comm_wr, comm_wdata} = {1'b1, 16'h4D4D};
        cyc();
        comm_wr = 1'b0;
        chk("channel_shared_comm_reg", 16'h4D4D, channel_shared_comm_reg);
        // First pass runs on the reset selection
        for (int i = 0; i < 4; i++) begin
            if (i != 0) exec(OP_CRT | 16'(i));
            comm_rd = 1'b1;
            cyc();
            comm_rd = 1'b0;
            chk("comm_rd_done", 16'h0001, {15'h0000, comm_rd_done});
            chk("comm_rdata", tbl[i], comm_rdata);
        end
        $display("shared register test done");
    endtask : t_comm
    task automatic t_ctrl();
        logic [7:0] e = 8'h00;
        for (int i = 0; i < 8; i++) begin
            exec(OP_CRB | 16'h0010 | 16'(i));
            e[i] = 1'b1;
            chk("ctrl_hi_bits set", {8'h00, e}, {8'h00, ctrl_hi_bits});
        end
        for (int i = 0; i < 8; i += 2) begin
            exec(OP_CRB | 16'(i));
            e[i] = 1'b0;
            chk("ctrl_hi_bits clear", {8'h00, e}, {8'h00, ctrl_hi_bits});
        end
        // Bit 3 set is not this opcode; must be ignored
        exec(OP_CRB | 16'h0009);
        chk("ctrl_hi_bits foreign", 16'h00AA, {8'h00, ctrl_hi_bits});
        $display("control bit test done");
    endtask : t_ctrl
    task automatic t_dac();
        logic [15:0] pl [4] = '{16'h0000, 16'h00C5, 16'h2A00, 16'h2AC5};
        logic [15:0] cb [4] = '{16'h0096, 16'h00E7, 16'h0B00, 16'h0BE7};
        for (int m = 0; m < 4; m++) begin
            exec(OP_DM | 16'(m));
            chk("dac_slice_sel", 16'(m), {14'h0000, dac_slice_sel});
            dac_acc(1'b0, 1'b0);
            chk("dac_rd_done", 16'h0001, {15'h0000, dac_rd_done});
            chk("dac_rdata plain", pl[m], dac_rdata);
            dac_acc(1'b0, 1'b1);
            chk("dac_rdata combined", cb[m], dac_rdata);
        end
        exec(OP_DM);
        dac_acc(1'b1, 1'b0);
        chk("dac_wr_strobe plain", 16'h0000, {11'h000, dac_wr_strobe});
        dac_acc(1'b1, 1'b1);
        chk("dac_wr_strobe boost", 16'h0010, {11'h000, dac_wr_strobe});
        chk("dac_wr_data", 16'h3FFF, dac_wr_data);
        $display("dac access test done");
    endtask : t_dac
    task automatic t_ram();
        logic [15:0] e [4] = '{16'hA55C, 16'h005C, 16'h00A5, 16'h5CA5};
        int p = 0;
        for (int k = 1; k <= 4; k++) begin
            // Mode change and a load on one edge: that load keeps the old mode
            {instr_valid, instr_word, ram_rd_valid} = {1'b1, OP_DRM | 16'(k % 4), 1'b1};
            cyc();
            instr_valid = 1'b0;
            chk("ram_rd_result old", e[p], ram_rd_result);
            cyc();
            p = k % 4;
            chk("ram_rd_done", 16'h0001, {15'h0000, ram_rd_done});
            chk("ram_rd_result new", e[p], ram_rd_result);
        end
        // Load strobe held up across the loop, dropped once here
        ram_rd_valid = 1'b0;
        $display("read mode test done");
    endtask : t_ram
    task automatic t_conv();
        core_lowside_drive = 1'b1;
        cyc(2);
        chk("predriver core", 16'h0001, {15'h0000, converter_lowside_predriver});
        exec(OP_DCC | 16'h0001);
        chk("converter_mode_sel", 16'h0001, {15'h0000, converter_mode_sel});
        // Core request stays high; the loop alone must switch
        above_4h_pin = 1'b1;
        settle(1'b0);
        {above_4h_pin, below_4l_pin} = 2'b01;
        settle(1'b1);
        below_4l_pin = 1'b0;
        cyc(8);
        chk("predriver hold", 16'h0001, {15'h0000, converter_lowside_predriver});
        core_lowside_drive = 1'b0;
        exec(OP_DCC);
        cyc(2);
        chk("predriver back", 16'h0000, {15'h0000, converter_lowside_predriver});
        chk("ctrl_hi_bits kept", 16'h00AA, {8'h00, ctrl_hi_bits});
        $display("converter test done");
    endtask : t_conv
    //////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        #2 nrst = 1'b1;
        t_reset();
        t_comm();
        t_ctrl();
        t_dac();
        t_ram();
        t_conv();
        wrap_up();
    end
    // Watchdog, well past the roughly 120 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
